// ### core/wrc_pkg.sv
// package for the cpu working register context file
package wrc_pkg;
   localparam int DATA_W = 16;
   localparam int NUM_REGS = 16;
   localparam int NUM_ALT = 4;
   localparam int NUM_CTX = 5;
   localparam int CTX_W = 3;
   localparam int IDX_W = 4;
   localparam int INSTR_W = 24;
   localparam int PC_W = 23;
   localparam int IPL_W = 3;
   localparam int NEST_DEPTH = 8;
   localparam int NEST_W = 3;
   localparam logic [IDX_W-1:0] SP_IDX = 4'hf;
   localparam logic [CTX_W-1:0] CTX_MAIN = 3'h0;
   localparam logic [CTX_W-1:0] CTX_LAST = 3'h4;
   localparam logic [IPL_W-1:0] IPL_LO = 3'h1;
   localparam logic [IPL_W-1:0] IPL_HI = 3'h6;
   localparam logic [DATA_W-1:0] REG_RST = 16'h0000;
   localparam logic [PC_W-1:0] PC_RST = 23'h000000;
   localparam int CFG_W = NUM_ALT * CTX_W;
   // instruction timing classes
   typedef enum logic [1:0] {
      WRC_SINGLE = 2'b00,
      WRC_FLOW = 2'b01,
      WRC_MOVD = 2'b10,
      WRC_TABLE = 2'b11
   } wrc_class_e;
   typedef enum logic [1:0] {
      WRC_RUN = 2'b00,
      WRC_STALL = 2'b01
   } wrc_state_e;
   // register file access port
   typedef struct packed {
      logic rd_en;
      logic [IDX_W-1:0] rd_idx;
      logic wr_en;
      logic [IDX_W-1:0] wr_idx;
      logic [DATA_W-1:0] wr_data;
   } wrc_access_s;
   // context status word
   typedef struct packed {
      logic [CTX_W-1:0] manual_context_index;
      logic [CTX_W-1:0] current_context_index;
   } wrc_status_s;
   typedef logic [NUM_CTX-1:0][NUM_REGS-2:0][DATA_W-1:0] wrc_bank_t;
   typedef logic [NEST_DEPTH-1:0][CTX_W-1:0] wrc_nest_t;
   typedef struct packed {
      wrc_bank_t banks;
      logic [DATA_W-1:0] software_stack_pointer;
      logic [CTX_W-1:0] cur_ctx;
      logic [CTX_W-1:0] man_ctx;
      wrc_nest_t nest;
      logic [NEST_W:0] nest_cnt;
      logic [DATA_W-1:0] rd_data;
      logic [PC_W-1:0] program_counter;
      wrc_state_e state;
      logic [1:0] stall_cnt;
      logic [DATA_W-1:0] loop_cnt;
   } wrc_state_s;
   // extra stall cycle counts of multi-cycle classes
   localparam logic [1:0] EXTRA_FLOW = 2'h1;
   localparam logic [1:0] EXTRA_MOVD = 2'h1;
   localparam logic [1:0] EXTRA_TABLE = 2'h2;
endpackage : wrc_pkg

// ### core/wrc_context_file.sv
// working register file with alternate contexts and fetch sequencing
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module wrc_context_file
   import wrc_pkg::*;
#(
   parameter int DEPTH = NEST_DEPTH
) (
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic i_enable,
   input wire wrc_access_s i_access,
   input wire logic [CFG_W-1:0] i_alternate_set_config_word,
   input wire logic i_context_swap_instruction,
   input wire logic [CTX_W-1:0] i_swap_target,
   input wire logic i_irq_entry,
   input wire logic [IPL_W-1:0] i_interrupt_priority_level,
   input wire logic i_irq_return,
   input wire logic i_instr_valid,
   input wire logic [INSTR_W-1:0] i_instr_word,
   input wire wrc_class_e i_instr_class,
   input wire logic i_program_space_visibility,
   input wire logic i_branch,
   input wire logic [PC_W-1:0] i_branch_target,
   input wire logic i_loop_start,
   input wire logic [DATA_W-1:0] i_loop_count,
   output logic [DATA_W-1:0] o_rd_data,
   output logic [DATA_W-1:0] o_stack_pointer_role,
   output wrc_status_s o_context_status_register,
   output logic [PC_W-1:0] o_program_counter,
   output logic o_instr_ready,
   output logic o_loop_active
);
   ////////////////////////////////////////////////////////////////////////
   wrc_state_s st_reg;
   wrc_state_s st_next;

   // set bound to a priority level, main set if none
   function automatic logic [CTX_W-1:0] ctx_for_level(
      input logic [CFG_W-1:0] cfg,
      input logic [IPL_W-1:0] lvl
   );
      logic [CTX_W-1:0] hit;
      hit = CTX_MAIN;
      if (lvl >= IPL_LO && lvl <= IPL_HI) begin
         for (int k = NUM_ALT - 1; k >= 0; k--) begin
            if (cfg[k*CTX_W +: CTX_W] == lvl) begin
               hit = CTX_W'(k + 1);
            end
         end
      end
      return hit;
   endfunction : ctx_for_level

   function automatic logic [1:0] extra_cycles(
      input wrc_class_e cls,
      input logic program_space_visibility
   );
      logic [1:0] n;
      n = 2'h0;
      case (cls)
         WRC_FLOW: n = EXTRA_FLOW;
         WRC_MOVD: n = EXTRA_MOVD;
         WRC_TABLE: n = EXTRA_TABLE;
         default: n = 2'h0;
      endcase
      if (program_space_visibility && n == 2'h0) begin
         n = EXTRA_MOVD;
      end
      return n;
   endfunction : extra_cycles

   ////////////////////////////////////////////////////////////////////////
   logic [CTX_W-1:0] irq_ctx;
   logic take_instr;
   assign irq_ctx = ctx_for_level(i_alternate_set_config_word,
      i_interrupt_priority_level);
   assign take_instr = i_instr_valid && st_reg.state == WRC_RUN;

   always_comb begin
      st_next = st_reg;
      if (i_access.rd_en) begin
         if (i_access.rd_idx == SP_IDX) begin
            st_next.rd_data = st_reg.software_stack_pointer;
         end else begin
            st_next.rd_data = st_reg.banks[st_reg.cur_ctx][i_access.rd_idx];
         end
      end
      if (i_access.wr_en) begin
         if (i_access.wr_idx == SP_IDX) begin
            st_next.software_stack_pointer = i_access.wr_data;
         end else begin
            st_next.banks[st_reg.cur_ctx][i_access.wr_idx] =
               i_access.wr_data;
         end
      end
      if (i_irq_entry) begin
         if (st_reg.nest_cnt < (NEST_W+1)'(DEPTH)) begin
            st_next.nest[st_reg.nest_cnt[NEST_W-1:0]] = st_reg.cur_ctx;
            st_next.nest_cnt = st_reg.nest_cnt + 1'b1;
         end
         if (irq_ctx != CTX_MAIN) begin
            st_next.cur_ctx = irq_ctx;
         end
      end else if (i_irq_return) begin
         if (st_reg.nest_cnt != '0) begin
            st_next.cur_ctx = st_reg.nest[st_reg.nest_cnt[NEST_W-1:0] - 1'b1];
            st_next.nest_cnt = st_reg.nest_cnt - 1'b1;
         end
      end else if (i_context_swap_instruction && i_swap_target <= CTX_LAST)
      begin
         st_next.cur_ctx = i_swap_target;
         st_next.man_ctx = i_swap_target;
      end
      case (st_reg.state)
         WRC_RUN: begin
            if (take_instr) begin
               if (i_branch) begin
                  st_next.program_counter = i_branch_target;
               end else begin
                  st_next.program_counter = st_reg.program_counter + 1'b1;
               end
               if (extra_cycles(i_instr_class, i_program_space_visibility)
                  != 2'h0) begin
                  st_next.state = WRC_STALL;
                  st_next.stall_cnt =
                     extra_cycles(i_instr_class, i_program_space_visibility);
               end
            end
         end
         WRC_STALL: begin
            st_next.stall_cnt = st_reg.stall_cnt - 1'b1;
            if (st_reg.stall_cnt == 2'h1) begin
               st_next.state = WRC_RUN;
            end
         end
         default: st_next.state = WRC_RUN;
      endcase
      if (i_loop_start) begin
         st_next.loop_cnt = i_loop_count;
      end else if (take_instr && st_reg.loop_cnt != '0) begin
         st_next.loop_cnt = st_reg.loop_cnt - 1'b1;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         st_reg <= '0;
         st_reg.program_counter <= PC_RST;
         st_reg.cur_ctx <= CTX_MAIN;
         st_reg.man_ctx <= CTX_MAIN;
         st_reg.state <= WRC_RUN;
         st_reg.software_stack_pointer <= REG_RST;
      end else if (i_enable) begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // instruction word width fixed by port
   assign o_rd_data = st_reg.rd_data;
   assign o_stack_pointer_role = st_reg.software_stack_pointer;
   assign o_context_status_register.current_context_index = st_reg.cur_ctx;
   assign o_context_status_register.manual_context_index = st_reg.man_ctx;
   assign o_program_counter = st_reg.program_counter;
   assign o_instr_ready = st_reg.state == WRC_RUN;
   assign o_loop_active = st_reg.loop_cnt != '0;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);

   sequence swap_req;
      i_enable && i_context_swap_instruction && !i_irq_entry
         && !i_irq_return && i_swap_target <= CTX_LAST;
   endsequence

   // entry from an empty nest, then a plain return
   sequence irq_enter_first;
      i_enable && i_irq_entry && st_reg.nest_cnt == '0;
   endsequence
   sequence irq_leave_now;
      i_enable && i_irq_return && !i_irq_entry;
   endsequence

   // banked write with no set change, then read of the same index
   sequence rf_write_plain;
      i_enable && i_access.wr_en && i_access.wr_idx != SP_IDX
         && !i_irq_entry && !i_irq_return && !i_context_swap_instruction;
   endsequence
   sequence rf_read_back;
      i_enable && i_access.rd_en && !i_access.wr_en
         && i_access.rd_idx == $past(i_access.wr_idx);
   endsequence

   swap_sets_current_a: assert property (
      swap_req |=> o_context_status_register.current_context_index
         == $past(i_swap_target))
      else $error("swap did not select set");
   swap_sets_manual_a: assert property (
      swap_req |=> o_context_status_register.manual_context_index
         == $past(i_swap_target))
      else $error("manual index not recorded");
   irq_entry_ctx_a: assert property (
      i_enable && i_irq_entry && irq_ctx != CTX_MAIN
         |=> o_context_status_register.current_context_index
            == $past(irq_ctx))
      else $error("bound set not activated");
   irq_roundtrip_a: assert property (
      irq_enter_first ##1 irq_leave_now
         |=> o_context_status_register.current_context_index
            == $past(o_context_status_register.current_context_index, 2))
      else $error("set not restored on return");
   sp_shared_a: assert property (
      (swap_req and !i_access.wr_en)
         |=> o_stack_pointer_role == $past(o_stack_pointer_role))
      else $error("stack pointer changed on swap");
   sp_write_a: assert property (
      i_enable && i_access.wr_en && i_access.wr_idx == SP_IDX
         |=> o_stack_pointer_role == $past(i_access.wr_data))
      else $error("stack pointer write lost");
   active_rw_a: assert property (
      rf_write_plain ##1 rf_read_back
         |=> o_rd_data == $past(i_access.wr_data, 2))
      else $error("active set readback wrong");
   pc_step_a: assert property (
      i_enable && take_instr && !i_branch && i_instr_class == WRC_SINGLE
         && !i_program_space_visibility
         |=> o_program_counter == $past(o_program_counter) + 1'b1
            && o_instr_ready)
      else $error("single cycle step wrong");
   slow_stall_a: assert property (
      i_enable && take_instr && i_instr_class == WRC_TABLE
         |=> !o_instr_ready)
      else $error("table instruction not stalled");
   pc_branch_a: assert property (
      i_enable && take_instr && i_branch
         |=> o_program_counter == $past(i_branch_target))
      else $error("branch target not loaded");
endmodule : wrc_context_file

// ### sim/wrc_irq_model.sv
// interrupt controller model issuing entry and return pulses
`timescale 1ns/1ps
module wrc_irq_model
   import wrc_pkg::*;
(
   input wire logic i_clock,
   output logic o_irq_entry,
   output logic [IPL_W-1:0] o_level,
   output logic o_irq_return
);
   initial begin
      o_irq_entry = 1'b0;
      o_level = 3'h0;
      o_irq_return = 1'b0;
   end
   task automatic enter(input logic [IPL_W-1:0] lvl);
      o_irq_entry = 1'b1;
      o_level = lvl;
      @(negedge i_clock);
      o_irq_entry = 1'b0;
      // level is stale once the pulse ends
      o_level = ~lvl;
   endtask : enter
   task automatic leave;
      o_irq_return = 1'b1;
      @(negedge i_clock);
      o_irq_return = 1'b0;
   endtask : leave
endmodule : wrc_irq_model

// ### sim/cpu_working_register_contexts_tb.sv
// self-checking bench for the working register context file
`timescale 1ns/1ps
module cpu_working_register_contexts_tb;
   import wrc_pkg::*;
   logic i_clock = 1'b0;
   logic i_reset = 1'b1;
   logic i_enable = 1'b1;
   wrc_access_s acc = '0;
   logic [CFG_W-1:0] cfg = {3'h7, 3'h0, 3'h6, 3'h3};
   logic swp = 1'b0;
   logic [CTX_W-1:0] tgt = '0;
   logic ivalid = 1'b0;
   logic [INSTR_W-1:0] iword = '0;
   wrc_class_e icls = WRC_SINGLE;
   logic program_space_visibility = 1'b0;
   logic br = 1'b0;
   logic [PC_W-1:0] btgt = '0;
   logic lstart = 1'b0;
   logic [DATA_W-1:0] lcnt = 16'h0003;
   logic irq_entry, irq_ret, rdy, lact;
   logic [IPL_W-1:0] interrupt_priority_level;
   logic [DATA_W-1:0] rd_data, sp, v;
   wrc_status_s stat;
   logic [PC_W-1:0] pc;
   logic [DATA_W-1:0] seed = 16'h0041;
   logic [DATA_W-1:0] mdl [NUM_CTX][NUM_REGS-1];
   int num_errors = 0;
   int checks_done = 0;
   always #2.5 i_clock = ~i_clock;
   wrc_irq_model wrc_irq_model_inst (.i_clock(i_clock),
      .o_irq_entry(irq_entry), .o_level(interrupt_priority_level), .o_irq_return(irq_ret));
   wrc_context_file wrc_context_file_inst (.i_clock(i_clock),
      .i_reset(i_reset), .i_enable(i_enable), .i_access(acc),
      .i_alternate_set_config_word(cfg),
      .i_context_swap_instruction(swp), .i_swap_target(tgt),
      .i_irq_entry(irq_entry), .i_interrupt_priority_level(interrupt_priority_level),
      .i_irq_return(irq_ret), .i_instr_valid(ivalid),
      .i_instr_word(iword), .i_instr_class(icls),
      .i_program_space_visibility(program_space_visibility), .i_branch(br),
      .i_branch_target(btgt), .i_loop_start(lstart),
      .i_loop_count(lcnt), .o_rd_data(rd_data),
      .o_stack_pointer_role(sp), .o_context_status_register(stat),
      .o_program_counter(pc), .o_instr_ready(rdy), .o_loop_active(lact));
   ///////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] xs();
      seed ^= seed << 7;
      seed ^= seed >> 9;
      seed ^= seed << 8;
      return seed;
   endfunction : xs
   function automatic logic [5:0] exp_stat(input int m, input int c);
      return {m[2:0], c[2:0]};
   endfunction : exp_stat
   function automatic int stall_of(input wrc_class_e c, input logic p);
      if (c == WRC_TABLE) return 2;
      if (c == WRC_SINGLE) return p ? 1 : 0;
      return 1;
   endfunction : stall_of
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask : chk
   task automatic summarize;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize
   task automatic wr(input int i, input logic [DATA_W-1:0] d);
      acc.wr_en = 1'b1;
      acc.wr_idx = i[IDX_W-1:0];
      acc.wr_data = d;
      @(negedge i_clock);
      acc.wr_en = 1'b0;
      acc.wr_data = ~d;
      // idle edge so a following call does not re-raise the strobe at once
      @(negedge i_clock);
   endtask : wr
   task automatic rd(input int i, output logic [DATA_W-1:0] q);
      acc.rd_en = 1'b1;
      acc.rd_idx = i[IDX_W-1:0];
      @(negedge i_clock);
      acc.rd_en = 1'b0;
      q = rd_data;
      @(negedge i_clock);
   endtask : rd
   task automatic swap(input int t);
      swp = 1'b1;
      tgt = t[CTX_W-1:0];
      @(negedge i_clock);
      swp = 1'b0;
      @(negedge i_clock);
   endtask : swap
   task automatic instr(input wrc_class_e c, input logic p);
      logic [PC_W-1:0] old;
      old = pc;
      ivalid = 1'b1;
      icls = c;
      program_space_visibility = p;
      iword = {8'h00, xs()};
      @(negedge i_clock);
      ivalid = 1'b0;
      chk(pc, br ? btgt : old + 1'b1);
      repeat (stall_of(c, p)) begin
         chk(rdy, 1'b0);
         @(negedge i_clock);
      end
      chk(rdy, 1'b1);
      @(negedge i_clock);
   endtask : instr
   ///////////////////////////////////////////////////////////////////////
   initial begin
      #20000;
      num_errors++;
      summarize();
   end
   initial begin
      repeat (8) @(negedge i_clock);
      i_reset = 1'b0;
      chk(stat, exp_stat(0, 0));
      chk(pc, PC_RST);
      for (int c = 0; c < NUM_CTX; c++) begin
         swap(c);
         chk(stat, exp_stat(c, c));
         for (int r = 0; r < NUM_REGS - 1; r++) begin
            mdl[c][r] = xs();
            wr(r, mdl[c][r]);
         end
      end
      wr(15, 16'hbeef);
      chk(sp, 16'hbeef);
      for (int c = NUM_CTX - 1; c >= 0; c--) begin
         swap(c);
         for (int r = 0; r < NUM_REGS - 1; r++) begin
            rd(r, v);
            chk(v, mdl[c][r]);
         end
         rd(15, v);
         chk(v, 16'hbeef);
      end
      // write then read back the same banked register on the next edge
      acc.wr_en = 1'b1;
      acc.wr_idx = 4'h3;
      acc.wr_data = xs();
      mdl[0][3] = acc.wr_data;
      @(negedge i_clock);
      acc.wr_en = 1'b0;
      acc.rd_en = 1'b1;
      acc.rd_idx = 4'h3;
      @(negedge i_clock);
      acc.rd_en = 1'b0;
      chk(rd_data, mdl[0][3]);
      swap(5);
      chk(stat, exp_stat(0, 0));
      i_enable = 1'b0;
      swap(2);
      chk(stat, exp_stat(0, 0));
      i_enable = 1'b1;
      wrc_irq_model_inst.enter(3'h3);
      chk(stat, exp_stat(0, 1));
      rd(0, v);
      chk(v, mdl[1][0]);
      wrc_irq_model_inst.enter(3'h6);
      chk(stat, exp_stat(0, 2));
      @(negedge i_clock);
      wrc_irq_model_inst.enter(3'h7);
      chk(stat, exp_stat(0, 2));
      wrc_irq_model_inst.leave();
      chk(stat, exp_stat(0, 2));
      @(negedge i_clock);
      wrc_irq_model_inst.leave();
      chk(stat, exp_stat(0, 1));
      @(negedge i_clock);
      wrc_irq_model_inst.leave();
      chk(stat, exp_stat(0, 0));
      for (int k = 0; k < 24; k++) begin
         v = xs();
         if (k < 8) v = k[15:0];
         instr(wrc_class_e'(v[1:0]), v[2]);
      end
      br = 1'b1;
      btgt = {7'h00, xs()} | 23'h400000;
      instr(WRC_FLOW, 1'b0);
      br = 1'b0;
      lstart = 1'b1;
      @(negedge i_clock);
      lstart = 1'b0;
      chk(lact, 1'b1);
      instr(WRC_SINGLE, 1'b0);
      wrc_irq_model_inst.enter(3'h3);
      chk(stat, exp_stat(0, 1));
      chk(lact, 1'b1);
      wrc_irq_model_inst.leave();
      instr(WRC_SINGLE, 1'b0);
      chk(lact, 1'b1);
      instr(WRC_SINGLE, 1'b0);
      chk(lact, 1'b0);
      i_reset = 1'b1;
      @(negedge i_clock);
      i_reset = 1'b0;
      chk(pc, PC_RST);
      chk(sp, REG_RST);
      summarize();
   end
endmodule : cpu_working_register_contexts_tb
